//--- hw/uef_pkg.sv
package uef_pkg;

  // Register indexes; the bus byte address is four times the index.
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned ADDR_LSB   = 2;
  localparam int unsigned IDX_W      = 6;
  localparam logic [7:0]  IDX_INDEX  = 8'h00;
  localparam logic [7:0]  IDX_IN_FLG = 8'h02;
  localparam logic [7:0]  IDX_OUT_FLG = 8'h04;
  localparam logic [7:0]  IDX_CM_FLG = 8'h06;
  localparam logic [7:0]  IDX_IN_IE  = 8'h07;
  localparam logic [7:0]  IDX_OUT_IE = 8'h09;
  localparam logic [7:0]  IDX_CM_IE  = 8'h0B;
  localparam logic [7:0]  IDX_EP0_CSR = 8'h11;
  localparam logic [7:0]  IDX_EP0_CNT = 8'h16;
  localparam logic [7:0]  IDX_CTRL   = 8'h20;
  localparam logic [7:0]  IDX_IN_LEN = 8'h21;
  localparam logic [7:0]  EP0_INDEX  = 8'h00;

  localparam logic [3:0]  RST_CM_IE  = 4'h6;
  localparam logic [1:0]  RST_IN_IE  = 2'h3;
  localparam logic        RST_OUT_IE = 1'b1;

  // Field positions.
  localparam int unsigned CM_SOF = 3;
  localparam int unsigned CM_RST = 2;
  localparam int unsigned CM_RSU = 1;
  localparam int unsigned CM_SUS = 0;
  localparam int unsigned EP_CTL = 0;
  localparam int unsigned EP_ONE = 1;
  localparam int unsigned CSR_OPR    = 0;
  localparam int unsigned CSR_INPR   = 1;
  localparam int unsigned CSR_STALL_SENT_FLAG  = 2;
  localparam int unsigned CSR_DEND   = 3;
  localparam int unsigned CSR_SETUP_END_FLAG  = 4;
  localparam int unsigned CSR_STALL_REQUEST  = 5;
  localparam int unsigned CSR_SOPR   = 6;
  localparam int unsigned CSR_SERVICED_SETUP_END = 7;
  localparam int unsigned CTRL_SUSPEND_DETECT_ENABLE = 0;

  localparam logic [7:0]  EP0_MAX_PKT = 8'h40;
  localparam logic [7:0]  SETUP_LEN   = 8'h08;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned FRAME_NS      = 1000000;
  localparam int unsigned FRAME_CYCLES  = FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAME_CNT_W   = 20;

  typedef enum logic [1:0] {
    PID_SETUP = 2'h0,
    PID_IN    = 2'h1,
    PID_OUT   = 2'h2,
    PID_SOF   = 2'h3
  } uef_pid_t;

  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2
  } uef_hs_code_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_TX      = 2'h1,
    ST_TX_STAT = 2'h3,
    ST_RX      = 2'h2
  } uef_state_t;

  typedef struct packed {
    logic     valid;
    uef_pid_t pid;
  } uef_token_t;

  typedef struct packed {
    logic       done;
    logic       ok;
    logic [7:0] len;
  } uef_rx_t;

  typedef struct packed {
    logic         valid;
    uef_hs_code_t code;
  } uef_hs_t;

  typedef struct packed {
    logic       start;
    logic [6:0] len;
  } uef_tx_t;

  typedef struct packed {
    logic bus_reset;
    logic resume;
    logic suspend;
  } uef_line_t;

endpackage : uef_pkg

//--- hw/uef_top.sv
// Summary of operation
// - Set frame flag on SOF or expected frame time
// - Reading common event flags clears them all
// - Bus reset detection sets reset flag
// - Resume sets flag only while suspended
// - Suspend sets flag only when detection enabled
// - One enable bit per interrupt source
// - Reset enables endpoint, reset, resume interrupts
// - Automatic handshakes; interrupt after complete packets
// - Corrupted packets never interrupt
// - Four causes plus SETUP/OUT setup-end raise control endpoint interrupt
// - Count register holds received byte count
// - Four protocol errors or request force STALL
// - Every STALL sets sent flag and interrupts
// - SETUP must be exactly eight bytes
// - Interrupt after IN sent; none when empty
// - First IN enters transmit; SETUP/OUT sets setup-end
// - Leave transmit on SETUP/OUT/short; NAK when empty
// - Good OUT sets out-ready and interrupts
// - First OUT enters receive; SETUP/IN sets setup-end
// - Leave receive on SETUP/IN/short/zero-length
// - Interrupt request when any enabled flag set
// - Serviced write clears out-ready; reads zero
// - Serviced setup-end write clears setup-end
// - Send-stall request clears once STALL sent
module uef_top
  import uef_pkg::*;
#(
  parameter int unsigned FRAME_CYC = FRAME_CYCLES
) (
  input  wire logic               clock_i,
  input  wire logic               rstn_i,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr_i,
  input  wire logic               s_axi_awvalid_i,
  output      logic               s_axi_awready_o,
  input  wire logic [31:0]        s_axi_wdata_i,
  input  wire logic [3:0]         s_axi_wstrb_i,
  input  wire logic               s_axi_wvalid_i,
  output      logic               s_axi_wready_o,
  output      logic [1:0]         s_axi_bresp_o,
  output      logic               s_axi_bvalid_o,
  input  wire logic               s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr_i,
  input  wire logic               s_axi_arvalid_i,
  output      logic               s_axi_arready_o,
  output      logic [31:0]        s_axi_rdata_o,
  output      logic [1:0]         s_axi_rresp_o,
  output      logic               s_axi_rvalid_o,
  input  wire logic               s_axi_rready_i,
  input  wire uef_token_t         tok_i,
  input  wire uef_rx_t            rx_i,
  input  wire logic               tx_ack_i,
  input  wire uef_line_t          line_i,
  input  wire logic               suspended_i,
  input  wire logic               in1_evt_i,
  input  wire logic               out1_evt_i,
  output      uef_hs_t            hs_o,
  output      uef_tx_t            tx_o,
  output      logic               irq_o
);

  // Bus slave: one write and one read in flight, each accepted with a one-cycle ready.
  logic              awready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;

  wire               wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~awready_q & ~bvalid_q;
  wire               rd_go = s_axi_arvalid_i & ~arready_q & ~rvalid_q;
  wire               wr_en = awready_q;
  wire               rd_en = arready_q;
  wire [IDX_W-1:0]   wa_idx = s_axi_awaddr_i[ADDR_LSB +: IDX_W];
  wire [IDX_W-1:0]   ra_idx = s_axi_araddr_i[ADDR_LSB +: IDX_W];
  wire [7:0]         wd = s_axi_wdata_i[7:0];
  wire               wlane = wr_en & s_axi_wstrb_i[0];

  // Registers.
  logic [7:0]        index_q;
  logic [3:0]        cm_flg_q;
  logic [1:0]        in_flg_q;
  logic              out_flg_q;
  logic [3:0]        cm_ie_q;
  logic [1:0]        in_ie_q;
  logic              out_ie_q;
  logic              suspend_detect_enable_q;
  logic [6:0]        in_len_q;
  logic              opr_q;
  logic              inpr_q;
  logic              stall_sent_flag_q;
  logic              dend_q;
  logic              setup_end_flag_q;
  logic              stall_request_q;
  logic [6:0]        cnt_q;
  uef_state_t        state_q;
  uef_state_t        state_d;
  uef_pid_t          tok_q;
  logic              tx_busy_q;
  logic              tx_busy_d;
  logic              tx_stat_q;
  logic              tx_stat_d;
  logic [FRAME_CNT_W-1:0] frame_cnt_q;
  logic              frame_arm_q;
  uef_hs_t           hs_q;
  uef_hs_t           hs_d;
  uef_tx_t           tx_q;
  uef_tx_t           tx_d;
  logic              irq_q;

  // Engine event terms.
  logic              ep0_evt;
  logic              set_opr;
  logic              clr_inpr;
  logic              set_stall_sent_flag;
  logic              clr_stall_request;
  logic              set_setup_end_flag;
  logic              clr_dend;
  logic              cnt_ld;

  wire csr_sel = (index_q == EP0_INDEX);
  wire w_index  = wlane & (wa_idx == IDX_INDEX[IDX_W-1:0]);
  wire w_cm_ie  = wlane & (wa_idx == IDX_CM_IE[IDX_W-1:0]);
  wire w_in_ie  = wlane & (wa_idx == IDX_IN_IE[IDX_W-1:0]);
  wire w_out_ie = wlane & (wa_idx == IDX_OUT_IE[IDX_W-1:0]);
  wire w_ctrl   = wlane & (wa_idx == IDX_CTRL[IDX_W-1:0]);
  wire w_in_len = wlane & (wa_idx == IDX_IN_LEN[IDX_W-1:0]);
  wire w_csr    = wlane & csr_sel & (wa_idx == IDX_EP0_CSR[IDX_W-1:0]);
  wire wr_hit   = (wa_idx == IDX_INDEX[IDX_W-1:0])   | (wa_idx == IDX_CM_IE[IDX_W-1:0])
                | (wa_idx == IDX_IN_IE[IDX_W-1:0])   | (wa_idx == IDX_OUT_IE[IDX_W-1:0])
                | (wa_idx == IDX_CTRL[IDX_W-1:0])    | (wa_idx == IDX_IN_LEN[IDX_W-1:0])
                | (wa_idx == IDX_EP0_CSR[IDX_W-1:0]) | (wa_idx == IDX_CM_FLG[IDX_W-1:0])
                | (wa_idx == IDX_IN_FLG[IDX_W-1:0])  | (wa_idx == IDX_OUT_FLG[IDX_W-1:0])
                | (wa_idx == IDX_EP0_CNT[IDX_W-1:0]);

  // Software strobes in the control endpoint register.
  wire sw_sopr   = w_csr & wd[CSR_SOPR];
  wire sw_serviced_setup_end = w_csr & wd[CSR_SERVICED_SETUP_END];
  wire sw_inpr   = w_csr & wd[CSR_INPR];
  wire sw_dend   = w_csr & wd[CSR_DEND];
  wire sw_ststl0 = w_csr & ~wd[CSR_STALL_SENT_FLAG];

  // Read-to-clear strobes.
  wire rc_cm  = rd_en & (ra_idx == IDX_CM_FLG[IDX_W-1:0]);
  wire rc_in  = rd_en & (ra_idx == IDX_IN_FLG[IDX_W-1:0]);
  wire rc_out = rd_en & (ra_idx == IDX_OUT_FLG[IDX_W-1:0]);

  wire [7:0] csr_rd = {2'b00, stall_request_q, setup_end_flag_q, dend_q, stall_sent_flag_q, inpr_q, opr_q};

  wire [7:0] rd_val =
      (ra_idx == IDX_INDEX[IDX_W-1:0])   ? index_q :
      (ra_idx == IDX_CM_FLG[IDX_W-1:0])  ? {4'h0, cm_flg_q} :
      (ra_idx == IDX_IN_FLG[IDX_W-1:0])  ? {6'h00, in_flg_q} :
      (ra_idx == IDX_OUT_FLG[IDX_W-1:0]) ? {6'h00, out_flg_q, 1'b0} :
      (ra_idx == IDX_CM_IE[IDX_W-1:0])   ? {4'h0, cm_ie_q} :
      (ra_idx == IDX_IN_IE[IDX_W-1:0])   ? {6'h00, in_ie_q} :
      (ra_idx == IDX_OUT_IE[IDX_W-1:0])  ? {6'h00, out_ie_q, 1'b0} :
      (ra_idx == IDX_CTRL[IDX_W-1:0])    ? {7'h00, suspend_detect_enable_q} :
      (ra_idx == IDX_IN_LEN[IDX_W-1:0])  ? {1'b0, in_len_q} :
      (ra_idx == IDX_EP0_CSR[IDX_W-1:0]) ? (csr_sel ? csr_rd : 8'h00) :
      (ra_idx == IDX_EP0_CNT[IDX_W-1:0]) ? {1'b0, cnt_q} : 8'h00;
  wire rd_hit = (ra_idx == IDX_INDEX[IDX_W-1:0])   | (ra_idx == IDX_CM_FLG[IDX_W-1:0])
              | (ra_idx == IDX_IN_FLG[IDX_W-1:0])  | (ra_idx == IDX_OUT_FLG[IDX_W-1:0])
              | (ra_idx == IDX_CM_IE[IDX_W-1:0])   | (ra_idx == IDX_IN_IE[IDX_W-1:0])
              | (ra_idx == IDX_OUT_IE[IDX_W-1:0])  | (ra_idx == IDX_CTRL[IDX_W-1:0])
              | (ra_idx == IDX_IN_LEN[IDX_W-1:0])  | (ra_idx == IDX_EP0_CSR[IDX_W-1:0])
              | (ra_idx == IDX_EP0_CNT[IDX_W-1:0]);

  // The frame flag is synthesised when a frame slot passes without a good SOF.
  wire sof_tok   = tok_i.valid & (tok_i.pid == PID_SOF);
  wire frame_end = frame_arm_q & (frame_cnt_q == FRAME_CNT_W'(FRAME_CYC - 1));
  wire [3:0] cm_set;
  assign cm_set[CM_SOF] = sof_tok | frame_end;
  assign cm_set[CM_RST] = line_i.bus_reset;
  assign cm_set[CM_RSU] = line_i.resume & suspended_i;
  assign cm_set[CM_SUS] = line_i.suspend & suspend_detect_enable_q;

  wire short_in  = ({1'b0, in_len_q} < EP0_MAX_PKT);
  wire rx_big    = (rx_i.len > EP0_MAX_PKT);

  // Endpoint zero handshake engine. Tokens, packet ends and host ACKs are separate
  // bus events, so at most one of them arrives in any cycle.
  always_comb begin
    state_d   = state_q;
    tx_busy_d = tx_busy_q;
    tx_stat_d = tx_stat_q;
    hs_d      = '{valid: 1'b0, code: HS_ACK};
    tx_d      = '{start: 1'b0, len: 7'h00};
    ep0_evt   = 1'b0;
    set_opr   = 1'b0;
    clr_inpr  = 1'b0;
    set_stall_sent_flag = 1'b0;
    clr_stall_request = 1'b0;
    set_setup_end_flag = 1'b0;
    clr_dend  = 1'b0;
    cnt_ld    = 1'b0;
    if (tok_i.valid && tok_i.pid == PID_IN) begin
      tx_busy_d = 1'b0;
      if (stall_request_q || state_q == ST_TX_STAT) begin
        hs_d = '{valid: 1'b1, code: HS_STALL};
      end else if (dend_q && !inpr_q && state_q != ST_TX) begin
        tx_d      = '{start: 1'b1, len: 7'h00};
        tx_busy_d = 1'b1;
        tx_stat_d = 1'b1;
        state_d   = ST_IDLE;
      end else begin
        if (state_q == ST_RX) begin
          set_setup_end_flag = 1'b1;
        end
        state_d = ST_TX;
        if (!inpr_q) begin
          hs_d = '{valid: 1'b1, code: HS_NAK};
        end else begin
          tx_d      = '{start: 1'b1, len: in_len_q};
          tx_busy_d = 1'b1;
          tx_stat_d = 1'b0;
        end
      end
    end else if (tok_i.valid && tok_i.pid != PID_SOF) begin
      tx_busy_d = 1'b0;
      if ((state_q == ST_TX && !dend_q) ||
          (tok_i.pid == PID_SETUP && state_q == ST_RX && !dend_q)) begin
        set_setup_end_flag = 1'b1;
        ep0_evt   = 1'b1;
      end
      if (tok_i.pid == PID_SETUP || state_q == ST_TX) begin
        state_d = ST_IDLE;
      end
      if (tok_i.pid == PID_SETUP) begin
        clr_dend = 1'b1;
      end
    end else if (rx_i.done && rx_i.ok) begin
      if (tok_q == PID_SETUP) begin
        if (rx_i.len == SETUP_LEN) begin
          hs_d     = '{valid: 1'b1, code: HS_ACK};
          set_opr  = 1'b1;
          cnt_ld   = 1'b1;
          clr_inpr = inpr_q;
          ep0_evt  = 1'b1;
        end
      end else if (tok_q == PID_OUT) begin
        if (stall_request_q || rx_big || dend_q && state_q != ST_TX_STAT
            || state_q == ST_TX_STAT && rx_i.len != 8'h00) begin
          hs_d = '{valid: 1'b1, code: HS_STALL};
        end else if (state_q == ST_TX_STAT) begin
          hs_d     = '{valid: 1'b1, code: HS_ACK};
          ep0_evt  = 1'b1;
          clr_dend = 1'b1;
          state_d  = ST_IDLE;
        end else if (opr_q) begin
          hs_d = '{valid: 1'b1, code: HS_NAK};
        end else begin
          hs_d     = '{valid: 1'b1, code: HS_ACK};
          set_opr  = 1'b1;
          cnt_ld   = 1'b1;
          clr_inpr = inpr_q;
          ep0_evt  = 1'b1;
          state_d  = (rx_i.len == EP0_MAX_PKT) ? ST_RX : ST_IDLE;
        end
      end
    end else if (tx_ack_i && tx_busy_q) begin
      tx_busy_d = 1'b0;
      ep0_evt   = 1'b1;
      if (tx_stat_q) begin
        clr_dend = 1'b1;
        state_d  = ST_IDLE;
      end else begin
        clr_inpr = 1'b1;
        if (dend_q) begin
          state_d = ST_TX_STAT;
        end else if (short_in) begin
          state_d = ST_IDLE;
        end
      end
    end
    if (hs_d.valid && hs_d.code == HS_STALL) begin
      set_stall_sent_flag = 1'b1;
      clr_stall_request = 1'b1;
      ep0_evt   = 1'b1;
      clr_dend  = 1'b1;
      state_d   = ST_IDLE;
    end
  end

  // Pending flags: a hardware set in the same cycle as a clearing read is kept.
  wire [3:0] cm_flg_d  = cm_set | (cm_flg_q & ~{4{rc_cm}});
  wire [1:0] in_set    = {in1_evt_i, ep0_evt};
  wire [1:0] in_flg_d  = in_set | (in_flg_q & ~{2{rc_in}});
  wire       out_flg_d = out1_evt_i | (out_flg_q & ~rc_out);
  wire       irq_d = |(cm_flg_q & cm_ie_q) | |(in_flg_q & in_ie_q)
                   | (out_flg_q & out_ie_q);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      awready_q <= wr_go;
      arready_q <= rd_go;
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
      if (rd_en) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= {24'h000000, rd_val};
      end else if (s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      index_q  <= EP0_INDEX;
      cm_ie_q  <= RST_CM_IE;
      in_ie_q  <= RST_IN_IE;
      out_ie_q <= RST_OUT_IE;
      suspend_detect_enable_q  <= 1'b0;
      in_len_q <= '0;
    end else begin
      if (w_index) index_q <= wd;
      if (w_cm_ie) cm_ie_q <= wd[3:0];
      if (w_in_ie) in_ie_q <= wd[1:0];
      if (w_out_ie) out_ie_q <= wd[EP_ONE];
      if (w_ctrl) suspend_detect_enable_q <= wd[CTRL_SUSPEND_DETECT_ENABLE];
      if (w_in_len) in_len_q <= wd[6:0];
    end
  end

  // Flags are set whatever the enables say; only the request is gated.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cm_flg_q  <= '0;
      in_flg_q  <= '0;
      out_flg_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      cm_flg_q  <= cm_flg_d;
      in_flg_q  <= in_flg_d;
      out_flg_q <= out_flg_d;
      irq_q     <= irq_d;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opr_q   <= 1'b0;
      inpr_q  <= 1'b0;
      stall_sent_flag_q <= 1'b0;
      dend_q  <= 1'b0;
      setup_end_flag_q <= 1'b0;
      stall_request_q <= 1'b0;
      cnt_q   <= '0;
    end else begin
      opr_q   <= set_opr | (opr_q & ~sw_sopr);
      inpr_q  <= sw_inpr | (inpr_q & ~clr_inpr);
      stall_sent_flag_q <= set_stall_sent_flag | (stall_sent_flag_q & ~sw_ststl0);
      dend_q  <= sw_dend | (dend_q & ~clr_dend);
      setup_end_flag_q <= set_setup_end_flag | (setup_end_flag_q & ~sw_serviced_setup_end);
      if (w_csr) begin
        stall_request_q <= wd[CSR_STALL_REQUEST];
      end else if (clr_stall_request) begin
        stall_request_q <= 1'b0;
      end
      if (cnt_ld) cnt_q <= rx_i.len[6:0];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q   <= ST_IDLE;
      tok_q     <= PID_SETUP;
      tx_busy_q <= 1'b0;
      tx_stat_q <= 1'b0;
      hs_q      <= '{valid: 1'b0, code: HS_ACK};
      tx_q      <= '{start: 1'b0, len: 7'h00};
    end else begin
      state_q   <= state_d;
      tx_busy_q <= tx_busy_d;
      tx_stat_q <= tx_stat_d;
      hs_q      <= hs_d;
      tx_q      <= tx_d;
      if (tok_i.valid && tok_i.pid != PID_SOF) tok_q <= tok_i.pid;
    end
  end

  // The frame timer only free-runs after a first SOF, and a bus reset stops it.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_cnt_q <= '0;
      frame_arm_q <= 1'b0;
    end else if (line_i.bus_reset) begin
      frame_cnt_q <= '0;
      frame_arm_q <= 1'b0;
    end else if (sof_tok || frame_end) begin
      frame_cnt_q <= '0;
      frame_arm_q <= 1'b1;
    end else if (frame_arm_q) begin
      frame_cnt_q <= frame_cnt_q + 1'b1;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = awready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rresp_o   = rresp_q;
  assign s_axi_rdata_o   = rdata_q;
  assign hs_o            = hs_q;
  assign tx_o            = tx_q;
  assign irq_o           = irq_q;

endmodule : uef_top

//--- sim/uef_host_model.sv
module uef_host_model
  import uef_pkg::*;
(
  input  wire logic    clock_i,
  input  wire uef_hs_t hs_o,
  input  wire uef_tx_t tx_o,
  output uef_token_t   tok_i,
  output uef_rx_t      rx_i,
  output logic         tx_ack_i,
  output uef_line_t    line_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tok_i = '0;
    rx_i = '0;
    tx_ack_i = '0;
    line_i = '0;
  end
  // A released token or length shows the inverse of its last value, never a stale copy.
  task automatic token(input uef_pid_t p, output uef_hs_t hs, output uef_tx_t tx);
    tok_i <= '{1'h1, p};
    @(posedge clock_i);
    tok_i <= '{1'h0, uef_pid_t'(~p)};
    #1 hs = hs_o;
    tx = tx_o;
  endtask : token
  task automatic data(input logic ok, input logic [7:0] l, output uef_hs_t hs);
    rx_i <= '{1'h1, ok, l};
    @(posedge clock_i);
    rx_i <= '{1'h0, 1'h0, ~l};
    #1 hs = hs_o;
  endtask : data
  task automatic ack();
    tx_ack_i <= 1'h1;
    @(posedge clock_i);
    tx_ack_i <= 1'h0;
    #1;
  endtask : ack
  task automatic pulse(input uef_line_t l);
    line_i <= l;
    @(posedge clock_i);
    line_i <= '0;
    #1;
  endtask : pulse
endmodule : uef_host_model

//--- sim/uef_monitor.sv
module uef_monitor
  import uef_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       s_axi_awvalid_i,
  input wire logic       s_axi_wvalid_i,
  input wire logic       s_axi_awready_o,
  input wire logic       s_axi_bvalid_o,
  input wire logic       s_axi_bready_i,
  input wire logic       s_axi_arvalid_i,
  input wire logic       s_axi_arready_o,
  input wire logic       s_axi_rvalid_o,
  input wire uef_token_t tok_i,
  input wire uef_rx_t    rx_i,
  input wire uef_hs_t    hs_o,
  input wire uef_tx_t    tx_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_setup;
    tok_i.valid && tok_i.pid == PID_SETUP ##1 rx_i.done && rx_i.ok;
  endsequence
  sequence s_wr;
    s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o && !s_axi_bvalid_o;
  endsequence
  a_setup_ack:
    assert property (s_setup ##0 rx_i.len == SETUP_LEN |=> hs_o.valid && hs_o.code == HS_ACK)
    else $error("good setup not acknowledged");
  a_setup_reject:
    assert property (s_setup ##0 rx_i.len != SETUP_LEN |=> !hs_o.valid)
    else $error("short setup answered");
  a_err_quiet:
    assert property (rx_i.done && !rx_i.ok |=> !hs_o.valid && !tx_o.start)
    else $error("corrupt packet answered");
  a_hs_cause:
    assert property (hs_o.valid |-> $past(tok_i.valid || rx_i.done))
    else $error("handshake without cause");
  a_tx_cause:
    assert property (tx_o.start |-> $past(tok_i.valid && tok_i.pid == PID_IN))
    else $error("data sent without in token");
  a_wr_answer:
    assert property (s_wr |=> s_axi_awready_o ##1 s_axi_bvalid_o)
    else $error("write answer late");
  a_rd_answer:
    assert property (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o
                     |=> s_axi_arready_o ##1 s_axi_rvalid_o)
    else $error("read answer late");
  a_b_hold:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
endmodule : uef_monitor

bind uef_top uef_monitor mon (.clock_i, .rstn_i, .s_axi_awvalid_i, .s_axi_wvalid_i,
  .s_axi_awready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .tok_i, .rx_i, .hs_o, .tx_o);

//--- sim/tb_usb_endpoint0_and_event_flags.sv
module tb_usb_endpoint0_and_event_flags
  import uef_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = '0, rstn_i = '0, suspended_i = '0, in1_evt_i = '0, out1_evt_i = '0;
  logic        s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
  logic        s_axi_arvalid_i = '0, s_axi_rready_i = '0, tx_ack_i, irq_o;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = '0;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp_q;
  uef_token_t  tok_i;
  uef_rx_t     rx_i;
  uef_line_t   line_i;
  uef_hs_t     hs_o, hs;
  uef_tx_t     tx_o, tx;
  int          err_count = 0, checks = 0, cm = 0, ie = 6;
  logic [31:0] r;
  logic [7:0]  en_ix[3] = '{IDX_IN_IE, IDX_OUT_IE, IDX_CM_IE};
  logic [7:0]  en_m[3] = '{8'h03, 8'h02, 8'h0F};
  always #2 clock_i = ~clock_i;
  uef_top #(.FRAME_CYC(200)) dut (.clock_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .tok_i, .rx_i, .tx_ack_i, .line_i, .suspended_i, .in1_evt_i, .out1_evt_i, .hs_o, .tx_o,
    .irq_o);
  uef_host_model host (.clock_i, .hs_o, .tx_o, .tok_i, .rx_i, .tx_ack_i, .line_i);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    @(posedge clock_i);
    s_axi_awaddr_i <= {ix[5:0], 2'h0};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_wstrb_i <= 4'hF;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    do @(posedge clock_i); while (!s_axi_awready_o);
    s_axi_awvalid_i <= 1'h0;
    s_axi_wvalid_i <= 1'h0;
    // A late ready makes the slave hold its response for a cycle.
    @(posedge clock_i);
    s_axi_bready_i <= 1'h1;
    do @(posedge clock_i); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'h0;
    resp_q = s_axi_bresp_o;
  endtask : wr
  task automatic rd(input logic [7:0] ix, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clock_i);
    s_axi_araddr_i <= {ix[5:0], 2'h0};
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do @(posedge clock_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'h0;
    do @(posedge clock_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'h0;
    resp_q = s_axi_rresp_o;
    chk(s_axi_rdata_o & {24'h0, m}, {24'h0, e});
  endtask : rd
  task automatic irqc();
    #1 chk({31'h0, irq_o}, {31'h0, |(cm & ie)});
  endtask : irqc
  task automatic rcm();
    rd(IDX_CM_FLG, cm[7:0]);
    cm = 0;
    irqc();
  endtask : rcm
  task automatic ev(input uef_line_t l, input int b);
    host.pulse(l);
    cm |= b;
    @(posedge clock_i);
    irqc();
  endtask : ev
  task automatic hsc(input logic v, input uef_hs_code_t c);
    chk({29'h0, hs}, {29'h0, v, v ? c : HS_ACK});
  endtask : hsc
  task automatic xfer(input uef_pid_t p, input logic ok, input logic [7:0] l);
    host.token(p, hs, tx);
    host.data(ok, l, hs);
  endtask : xfer
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(4));
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'h1;
    rd(IDX_IN_IE, 8'h03);
    rd(IDX_OUT_IE, 8'h02);
    rd(IDX_CM_IE, 8'h06);
    rd(IDX_CM_FLG, 8'h00);
    rd(8'h3F, 8'h00);
    chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    wr(8'h3E, 8'h00);
    chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      wr(en_ix[i%3], r[7:0]);
      rd(en_ix[i%3], r[7:0] & en_m[i%3]);
    end
    wr(IDX_CM_IE, 8'h06);
    chk({30'h0, resp_q}, {30'h0, RESP_OKAY});
    wr(IDX_IN_IE, 8'h03);
    $display("test registers done");
    ev('{1'h1, 1'h0, 1'h0}, 4);
    rcm();
    rd(IDX_CM_FLG, 8'h00);
    ev('{1'h0, 1'h1, 1'h0}, 0);
    suspended_i <= 1'h1;
    ev('{1'h0, 1'h1, 1'h0}, 2);
    suspended_i <= 1'h0;
    rcm();
    ev('{1'h0, 1'h0, 1'h1}, 0);
    wr(IDX_CTRL, 8'h01);
    ev('{1'h0, 1'h0, 1'h1}, 1);
    rcm();
    host.token(PID_SOF, hs, tx);
    cm = 8;
    rcm();
    repeat (210) @(posedge clock_i);
    cm = 8;
    rcm();
    ev('{1'h1, 1'h0, 1'h0}, 4);
    rcm();
    $display("test events done");
    wr(IDX_INDEX, EP0_INDEX);
    xfer(PID_SETUP, 1'h1, 8'h07);
    hsc(1'h0, HS_ACK);
    xfer(PID_SETUP, 1'h0, 8'h08);
    hsc(1'h0, HS_ACK);
    rd(IDX_IN_FLG, 8'h00);
    xfer(PID_SETUP, 1'h1, 8'h08);
    hsc(1'h1, HS_ACK);
    rd(IDX_EP0_CSR, 8'h01);
    rd(IDX_EP0_CNT, 8'h08);
    rd(IDX_IN_FLG, 8'h01);
    wr(IDX_EP0_CSR, 8'h40);
    rd(IDX_EP0_CSR, 8'h00);
    wr(IDX_IN_LEN, 8'h05);
    wr(IDX_EP0_CSR, 8'h0A);
    host.token(PID_IN, hs, tx);
    chk({24'h0, tx}, {24'h0, 1'h1, 7'h05});
    host.ack();
    rd(IDX_EP0_CSR, 8'h00, 8'h02);
    rd(IDX_IN_FLG, 8'h01);
    xfer(PID_OUT, 1'h1, 8'h00);
    hsc(1'h1, HS_ACK);
    rd(IDX_IN_FLG, 8'h01);
    wr(IDX_EP0_CSR, 8'h20);
    host.token(PID_IN, hs, tx);
    hsc(1'h1, HS_STALL);
    rd(IDX_EP0_CSR, 8'h04);
    rd(IDX_IN_FLG, 8'h01);
    wr(IDX_EP0_CSR, 8'h00);
    xfer(PID_OUT, 1'h1, 8'h41);
    hsc(1'h1, HS_STALL);
    rd(IDX_EP0_CSR, 8'h04, 8'h04);
    wr(IDX_EP0_CSR, 8'h00);
    xfer(PID_SETUP, 1'h1, 8'h08);
    wr(IDX_EP0_CSR, 8'h40);
    wr(IDX_IN_LEN, EP0_MAX_PKT);
    wr(IDX_EP0_CSR, 8'h02);
    host.token(PID_IN, hs, tx);
    chk({24'h0, tx}, {24'h0, 1'h1, EP0_MAX_PKT[6:0]});
    host.ack();
    rd(IDX_IN_FLG, 8'h01);
    host.token(PID_IN, hs, tx);
    hsc(1'h1, HS_NAK);
    rd(IDX_IN_FLG, 8'h00);
    host.token(PID_OUT, hs, tx);
    rd(IDX_EP0_CSR, 8'h10, 8'h10);
    wr(IDX_EP0_CSR, 8'h80);
    rd(IDX_EP0_CSR, 8'h00, 8'h10);
    $display("test control endpoint done");
    stop_test();
  end
endmodule : tb_usb_endpoint0_and_event_flags
